/* src/scd_device.sv */
// Device end: serial command byte decoder with interface reset
//
// Added by the designer: the strobe and data interface to the registers.
`default_nettype none
module scd_device #(
	parameter int DATA_MAX = scd_pkg::DATA_MAX,
	parameter int RESET_ONES = scd_pkg::RESET_ONES,
	localparam int LW = $clog2(DATA_MAX + 1),
	localparam int OW = $clog2(RESET_ONES + 1)
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	scd_link_if.dev link,
	// Register side requests
	input wire logic [LW-1:0] xferLen,
	input wire logic [DATA_MAX-1:0] rdData,
	input wire logic diffMode,
	// Decoded command
	output logic cmdStrobe,
	output logic cmdRead,
	output logic [scd_pkg::ADDR_BITS-1:0] regAddr,
	output logic [2:0] chanSel,
	output logic [2:0] posInput,
	output logic [2:0] negInput,
	output logic negCommon,
	// Write data and resets
	output logic wrStrobe,
	output logic [DATA_MAX-1:0] wrData,
	output logic modeStrobe,
	output logic [2:0] modeChan,
	output logic linkReset
);
	// ------------------------------------------------------------
	// Channel to input mapping
	// ------------------------------------------------------------
	function automatic logic [2:0] pos_of(input logic [2:0] ch,
		input logic diff);
		pos_of = diff ? {ch[1:0], 1'b0} : ch;
	endfunction : pos_of

	function automatic logic [2:0] neg_of(input logic [2:0] ch);
		neg_of = {ch[1:0], 1'b1};
	endfunction : neg_of

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic sclkS1, sclkS2, sclkS3;
	logic dinS1, dinS2;
	logic csS1, csS2;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sclkS1 <= 1'b1;
			sclkS2 <= 1'b1;
			sclkS3 <= 1'b1;
			dinS1 <= 1'b0;
			dinS2 <= 1'b0;
			csS1 <= 1'b1;
			csS2 <= 1'b1;
		end else begin
			sclkS1 <= link.sclk;
			sclkS2 <= sclkS1;
			sclkS3 <= sclkS2;
			dinS1 <= link.din;
			dinS2 <= dinS1;
			csS1 <= link.csN;
			csS2 <= csS1;
		end
	end

	logic selected, rise, fall;
	assign selected = !csS2;
	assign rise = selected && sclkS2 && !sclkS3;
	assign fall = selected && !sclkS2 && sclkS3;

	// ------------------------------------------------------------
	// All-ones interface reset detector
	// ------------------------------------------------------------
	logic [OW-1:0] onesCnt;
	logic onesHit;
	assign onesHit = rise && dinS2 &&
		onesCnt == OW'(RESET_ONES - 1);

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !selected) begin
			onesCnt <= '0;
		end else if (rise) begin
			if (!dinS2 || onesHit) begin
				onesCnt <= '0;
			end else begin
				onesCnt <= OW'(onesCnt + 1'b1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			linkReset <= 1'b0;
		end else begin
			linkReset <= onesHit;
		end
	end

	// ------------------------------------------------------------
	// Frame state and bit counting
	// ------------------------------------------------------------
	scd_pkg::scd_dstate_t state;
	logic [LW-1:0] bitCnt;
	logic [DATA_MAX-1:0] shiftIn;
	logic [scd_pkg::CMD_BITS-1:0] cmdByte;
	logic cmdDone, lastBit, writeDone;

	assign cmdByte = {shiftIn[scd_pkg::CMD_BITS-2:0], dinS2};
	assign cmdDone = rise && !onesHit && state == scd_pkg::D_CMD &&
		bitCnt == LW'(scd_pkg::CMD_BITS - 1);
	assign lastBit = LW'(bitCnt + 1'b1) == xferLen;
	assign writeDone = rise && !onesHit &&
		state == scd_pkg::D_WRITE && lastBit;

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !selected || onesHit) begin
			state <= scd_pkg::D_CMD;
			bitCnt <= '0;
			shiftIn <= '0;
		end else if (cmdStrobe && xferLen == '0) begin
			state <= scd_pkg::D_CMD;
		end else if (rise) begin
			shiftIn <= {shiftIn[DATA_MAX-2:0], dinS2};
			case (state)
				scd_pkg::D_CMD: begin
					if (cmdDone) begin
						bitCnt <= '0;
						shiftIn <= '0;
						if (cmdByte[scd_pkg::CMD_DIR_BIT]) begin
							state <= scd_pkg::D_READ;
						end else begin
							state <= scd_pkg::D_WRITE;
						end
					end else begin
						bitCnt <= LW'(bitCnt + 1'b1);
					end
				end
				scd_pkg::D_WRITE, scd_pkg::D_READ: begin
					if (lastBit) begin
						state <= scd_pkg::D_CMD;
						bitCnt <= '0;
					end else begin
						bitCnt <= LW'(bitCnt + 1'b1);
					end
				end
				default: begin
					state <= scd_pkg::D_CMD;
					bitCnt <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Command decode outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmdStrobe <= 1'b0;
			cmdRead <= 1'b0;
			regAddr <= scd_pkg::CMD_REG_ADDR;
			chanSel <= 3'h0;
			posInput <= 3'h0;
			negInput <= 3'h0;
			negCommon <= 1'b1;
		end else begin
			cmdStrobe <= cmdDone;
			if (cmdDone) begin
				cmdRead <= cmdByte[scd_pkg::CMD_DIR_BIT];
				regAddr <= cmdByte[scd_pkg::ADDR_BITS-1:0];
				chanSel <= cmdByte[2:0];
				posInput <= pos_of(cmdByte[2:0], diffMode);
				negInput <= neg_of(cmdByte[2:0]);
				negCommon <= !diffMode;
			end
		end
	end

	// ------------------------------------------------------------
	// Write data and mode channel
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wrStrobe <= 1'b0;
			wrData <= '0;
			modeStrobe <= 1'b0;
			modeChan <= 3'h0;
		end else begin
			wrStrobe <= writeDone;
			modeStrobe <= writeDone &&
				regAddr[5:3] == scd_pkg::MODE_GROUP;
			if (writeDone) begin
				wrData <= {shiftIn[DATA_MAX-2:0], dinS2};
				if (regAddr[5:3] == scd_pkg::MODE_GROUP) begin
					modeChan <= regAddr[2:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read data shifter, changes on falling serial edge
	// ------------------------------------------------------------
	logic [DATA_MAX-1:0] shiftOut;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			shiftOut <= '0;
			link.dout <= 1'b0;
		end else if (cmdStrobe && cmdRead) begin
			shiftOut <= rdData << (DATA_MAX - int'(xferLen));
		end else if (fall && state == scd_pkg::D_READ) begin
			link.dout <= shiftOut[DATA_MAX-1];
			shiftOut <= {shiftOut[DATA_MAX-2:0], 1'b0};
		end
	end
endmodule : scd_device
`default_nettype wire

/* src/scd_host.sv */
// Host end: APB-controlled serial command transmitter
`default_nettype none
module scd_host #(
	parameter int DATA_MAX = scd_pkg::DATA_MAX,
	parameter int RESET_ONES = scd_pkg::RESET_ONES,
	parameter int SCLK_HALF = scd_pkg::SCLK_HALF_CYC,
	localparam int LW = $clog2(DATA_MAX + 1),
	localparam int BW = $clog2(RESET_ONES + 1),
	localparam int DW = $clog2(SCLK_HALF + 1)
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link
	scd_link_if.host link
);
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = a == scd_pkg::HOST_CTRL || a == scd_pkg::HOST_TXDATA ||
			a == scd_pkg::HOST_RXDATA || a == scd_pkg::HOST_STATUS;
	endfunction : is_mapped

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] cmdReg;
	logic [LW-1:0] lenReg;
	logic rstReq, startReq, busy, done;
	logic [DATA_MAX-1:0] txData, rxData;
	logic wrAcc;
	assign wrAcc = psel && penable && pready && pwrite;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmdReg <= 8'h00;
			lenReg <= '0;
			rstReq <= 1'b0;
			startReq <= 1'b0;
			txData <= '0;
		end else begin
			startReq <= 1'b0;
			if (wrAcc && paddr == scd_pkg::HOST_CTRL && !busy && !startReq) begin
				cmdReg <= pwdata[7:0];
				cmdReg[scd_pkg::CMD_ZERO_BIT] <= 1'b0;
				lenReg <= pwdata[scd_pkg::CTRL_LEN_LSB +: LW];
				rstReq <= pwdata[scd_pkg::CTRL_RST_BIT];
				startReq <= 1'b1;
			end
			if (wrAcc && paddr == scd_pkg::HOST_TXDATA) begin
				txData <= pwdata[DATA_MAX-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= !is_mapped(paddr);
			case (paddr)
				scd_pkg::HOST_CTRL: prdata <= 32'(cmdReg) |
					(32'(lenReg) << scd_pkg::CTRL_LEN_LSB) |
					(32'(rstReq) << scd_pkg::CTRL_RST_BIT);
				scd_pkg::HOST_TXDATA: prdata <= 32'(txData);
				scd_pkg::HOST_RXDATA: prdata <= 32'(rxData);
				scd_pkg::HOST_STATUS: prdata <=
					(32'(busy || startReq) << scd_pkg::STAT_BUSY_BIT) |
					(32'(done) << scd_pkg::STAT_DONE_BIT);
				default: prdata <= 32'h0;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Returning data synchroniser
	// ------------------------------------------------------------
	logic doutS1, doutS2;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			doutS1 <= 1'b0;
			doutS2 <= 1'b0;
		end else begin
			doutS1 <= link.dout;
			doutS2 <= doutS1;
		end
	end

	// ------------------------------------------------------------
	// Serial engine with clock divider
	// ------------------------------------------------------------
	scd_pkg::scd_hstate_t state;
	logic [DW-1:0] divCnt;
	logic [BW-1:0] bitCnt;
	logic [DATA_MAX-1:0] txShift;
	logic isRead, tick;
	assign tick = divCnt == DW'(SCLK_HALF - 1);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= scd_pkg::H_IDLE;
			divCnt <= '0;
			bitCnt <= '0;
			txShift <= '0;
			rxData <= '0;
			isRead <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			link.sclk <= 1'b1;
			link.din <= 1'b0;
			link.csN <= 1'b1;
		end else begin
			divCnt <= tick ? '0 : DW'(divCnt + 1'b1);
			case (state)
				scd_pkg::H_IDLE: begin
					divCnt <= '0;
					if (startReq) begin
						busy <= 1'b1;
						done <= 1'b0;
						bitCnt <= '0;
						link.csN <= 1'b0;
						isRead <= cmdReg[scd_pkg::CMD_DIR_BIT];
						txShift <= {cmdReg, (DATA_MAX - 8)'(0)};
						state <= rstReq ? scd_pkg::H_RESET : scd_pkg::H_CMD;
					end
				end
				scd_pkg::H_CMD, scd_pkg::H_DATA, scd_pkg::H_RESET: begin
					if (tick && link.sclk) begin
						if (state == scd_pkg::H_DATA && isRead && bitCnt != '0) begin
							rxData <= {rxData[DATA_MAX-2:0], doutS2};
						end
						if (state == scd_pkg::H_CMD &&
							bitCnt == BW'(scd_pkg::CMD_BITS)) begin
							bitCnt <= '0;
							rxData <= '0;
							txShift <= txData << (DATA_MAX - int'(lenReg));
							state <= lenReg == '0 ? scd_pkg::H_GAP :
								scd_pkg::H_DATA;
						end else if ((state == scd_pkg::H_DATA &&
							bitCnt == BW'(lenReg)) || (state == scd_pkg::H_RESET &&
							bitCnt == BW'(RESET_ONES))) begin
							state <= scd_pkg::H_GAP;
						end else begin
							link.sclk <= 1'b0;
							if (state == scd_pkg::H_RESET) begin
								link.din <= 1'b1;
							end else if (state == scd_pkg::H_DATA && isRead) begin
								link.din <= 1'b0;
							end else begin
								link.din <= txShift[DATA_MAX-1];
							end
							txShift <= {txShift[DATA_MAX-2:0], 1'b0};
						end
					end else if (tick) begin
						link.sclk <= 1'b1;
						bitCnt <= BW'(bitCnt + 1'b1);
					end
				end
				scd_pkg::H_GAP: begin
					link.csN <= 1'b1;
					link.din <= 1'b0;
					if (tick) begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= scd_pkg::H_IDLE;
					end
				end
				default: state <= scd_pkg::H_IDLE;
			endcase
		end
	end
endmodule : scd_host
`default_nettype wire

/* src/scd_link_if.sv */
// Four-wire serial link between host controller and device
`default_nettype none
interface scd_link_if;
	logic sclk;
	logic din;
	logic dout;
	logic csN;
	modport host (output sclk, output din, output csN, input dout);
	modport dev (input sclk, input din, input csN, output dout);
endinterface : scd_link_if
`default_nettype wire

/* src/scd_pkg.sv */
// Shared constants and types of the serial command decoder
`default_nettype none
package scd_pkg;
	// ------------------------------------------------------------
	// Command byte layout
	// ------------------------------------------------------------
	localparam int CMD_BITS = 8;
	localparam int ADDR_BITS = 6;
	localparam logic [5:0] CMD_REG_ADDR = 6'h00;
	localparam int CMD_ZERO_BIT = 7;
	localparam int CMD_DIR_BIT = 6;
	localparam logic [2:0] MODE_GROUP = 3'h7;
	localparam int DATA_MAX = 24;
	localparam int RESET_ONES = 32;
	// ------------------------------------------------------------
	// Host controller registers (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_TXDATA = 8'h04;
	localparam logic [7:0] HOST_RXDATA = 8'h08;
	localparam logic [7:0] HOST_STATUS = 8'h0c;
	localparam int CTRL_LEN_LSB = 8;
	localparam int CTRL_RST_BIT = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int REF_MHZ = 40;
	localparam int SCLK_HALF_NS = 200;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * REF_MHZ + 999) / 1000;
	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {D_CMD, D_WRITE, D_READ} scd_dstate_t;
	typedef enum logic [2:0] {H_IDLE, H_CMD, H_DATA, H_RESET, H_GAP}
		scd_hstate_t;
endpackage : scd_pkg
`default_nettype wire

/* testbench/scd_link_sva.sv */
// Link protocol assertions of the serial command decoder
`default_nettype none
module scd_link_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic csN
);
	// ------------------------------------------------------------
	// Rising edges within the current frame
	// ------------------------------------------------------------
	logic [6:0] nRise;
	always_ff @(posedge ref_clk) begin
		if (!rst_n || csN) begin
			nRise <= 7'h00;
		end else if ($rose(sclk)) begin
			nRise <= nRise + 7'h01;
		end
	end
	// ------------------------------------------------------------
	// Properties, written for a half period of 8 cycles
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_idle_clk_high: assert property (csN && $past(csN) |-> sclk)
		else $error("serial clock low outside a frame");
	a_clk_in_frame: assert property ($fell(sclk) |-> !csN)
		else $error("serial clock falls without chip select");
	a_high_half: assert property ($rose(sclk) |-> sclk [*8])
		else $error("serial clock high phase too short");
	a_low_half: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
		else $error("serial clock low phase wrong length");
	a_din_steady: assert property (
		!csN && $past(!csN) && sclk && $past(sclk) |-> $stable(din))
		else $error("data in changes while clock high");
	a_dout_steady: assert property (
		$fell(sclk) |-> dout == $past(dout, 3))
		else $error("data out changes late in high phase");
	a_frame_start: assert property (
		$fell(csN) |-> ##[0:40] $fell(sclk))
		else $error("frame opened without clocking");
	a_frame_bits: assert property ($rose(csN) |-> nRise >= 7'd8)
		else $error("frame shorter than a command byte");
	a_end_gap: assert property ($rose(csN) |-> csN [*8])
		else $error("chip select gap too short");
	c_frame: cover property ($fell(csN));
	c_reset_frame: cover property ($rose(csN) && nRise == 7'd32);
	c_read_one: cover property (!csN && dout && $rose(sclk));
endmodule : scd_link_sva
`default_nettype wire

/* testbench/serial_command_register_decoder_tb.sv */
// Self-checking bench joining host and device ends
`default_nettype none
module serial_command_register_decoder_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, cmdStrobe, cmdRead, negCommon;
	logic wrStrobe, modeStrobe, linkReset, diffMode = 1'b0, quiet = 1'b0;
	logic [4:0] xferLen = 5'h00;
	logic [23:0] rdData = 24'h0;
	logic [23:0] wrData;
	logic [5:0] regAddr;
	logic [2:0] chanSel, posInput, negInput, modeChan;
	logic [35:0] notes[$];
	int n_errors = 0;
	int tests_run = 0;
	integer seed = 32'he92b25c7;
	scd_link_if link ();
	scd_host #(.SCLK_HALF(8)) scd_host_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	scd_device scd_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
		.xferLen(xferLen), .rdData(rdData), .diffMode(diffMode),
		.cmdStrobe(cmdStrobe), .cmdRead(cmdRead), .regAddr(regAddr),
		.chanSel(chanSel), .posInput(posInput), .negInput(negInput),
		.negCommon(negCommon), .wrStrobe(wrStrobe), .wrData(wrData),
		.modeStrobe(modeStrobe), .modeChan(modeChan), .linkReset(linkReset));
	scd_link_sva scd_link_sva_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.sclk(link.sclk), .din(link.din), .dout(link.dout), .csN(link.csN));
	initial forever #12.5 ref_clk = ~ref_clk;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [35:0] seen,
		input logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	function automatic logic [23:0] lenMask(input logic [4:0] len);
		logic [31:0] m;
		m = (32'h1 << len) - 32'h1;
		return m[23:0];
	endfunction : lenMask
	// Expected decode: direction, address and input routing
	function automatic logic [35:0] cmdNote(input logic [7:0] c,
		input logic d);
		if (d) return {4'h1, 15'h0, c[2:0], c[6:0], c[1:0], 1'b0, c[1:0],
			2'b10};
		return {4'h1, 15'h0, c[2:0], c[6:0], c[2:0], c[1:0], 2'b11};
	endfunction : cmdNote
	task automatic pop(input string what, input logic [35:0] seen);
		logic [35:0] exp;
		exp = 36'h0;
		if (notes.size() > 0) exp = notes.pop_front();
		check(what, seen, exp);
	endtask : pop
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			n_errors++;
			report_and_stop();
		end else begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb
	task automatic frame(input logic [7:0] cmd, input logic [4:0] len,
		input logic [23:0] txd, input logic rst);
		logic [31:0] r;
		logic e;
		int k;
		apb(1'b1, scd_pkg::HOST_TXDATA, {8'h0, txd}, r, e);
		apb(1'b1, scd_pkg::HOST_CTRL, {15'h0, rst, 3'h0, len, cmd}, r, e);
		for (k = 0; k < 2000; k++) begin
			apb(1'b0, scd_pkg::HOST_STATUS, 32'h0, r, e);
			if (r[0] === 1'b0) break;
		end
		if (k == 2000) begin
			n_errors++;
			report_and_stop();
		end else begin
			check("status after frame", {4'h0, r}, 36'h2);
		end
	endtask : frame
	// ------------------------------------------------------------
	// Monitor of decoded results
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (rst_n === 1'b1 && quiet === 1'b0) begin
			if (cmdStrobe === 1'b1) pop("command", {4'h1, 15'h0, chanSel,
				cmdRead, regAddr, posInput, negInput, negCommon});
			if (wrStrobe === 1'b1) pop("write data",
				{4'h2, 8'h0, wrData & lenMask(xferLen)});
			if (modeStrobe === 1'b1) pop("mode channel",
				{4'h3, 29'h0, modeChan});
		end
		if (rst_n === 1'b1 && linkReset === 1'b1) pop("link reset",
			{4'h4, 32'h0});
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		int i;
		int v;
		logic [7:0] cmd;
		logic [4:0] len;
		logic [23:0] tx;
		logic [31:0] r;
		logic e;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b0, scd_pkg::HOST_STATUS, 32'h0, r, e);
		check("status after reset", {3'h0, e, r}, 36'h0);
		apb(1'b0, 8'h10, 32'h0, r, e);
		check("unmapped read", {3'h0, e, r}, 36'h100000000);
		$display("test 1 done");
		for (i = 0; i < 16; i++) begin
			v = $random(seed);
			cmd = {v[7], 1'b0, v[5:3], i[2:0]};
			if (i[2:0] == 3'h7) cmd[5:3] = 3'h7;
			v = {$random(seed)} % 25;
			len = v[4:0];
			if (cmd[5:3] == 3'h7 && len == 5'h00) len = 5'h08;
			tx = 24'($random(seed));
			diffMode <= i[3];
			xferLen <= len;
			notes.push_back(cmdNote(cmd, i[3]));
			if (len != 5'h00) notes.push_back({4'h2, 8'h0, tx & lenMask(len)});
			if (len != 5'h00 && cmd[5:3] == 3'h7)
				notes.push_back({4'h3, 29'h0, cmd[2:0]});
			frame(cmd, len, tx, 1'b0);
		end
		$display("test 2 done");
		for (i = 0; i < 2; i++) begin
			v = $random(seed);
			cmd = {2'b01, v[5:0]};
			len = i ? 5'd24 : 5'd13;
			tx = 24'($random(seed));
			rdData <= tx;
			xferLen <= len;
			notes.push_back(cmdNote(cmd, diffMode));
			frame(cmd, len, 24'h0, 1'b0);
			apb(1'b0, scd_pkg::HOST_RXDATA, 32'h0, r, e);
			check("read data", {12'h0, r[23:0] & lenMask(len)},
				{12'h0, tx & lenMask(len)});
		end
		$display("test 3 done");
		quiet <= 1'b1;
		xferLen <= 5'd24;
		notes.push_back({4'h4, 32'h0});
		frame(8'h00, 5'h00, 24'h0, 1'b1);
		quiet <= 1'b0;
		xferLen <= 5'h08;
		notes.push_back(cmdNote(8'h2d, diffMode));
		notes.push_back({4'h2, 8'h0, 24'h0000a5});
		frame(8'h2d, 5'h08, 24'h0000a5, 1'b0);
		$display("test 4 done");
		repeat (20) @(posedge ref_clk);
		check("results left over", notes.size(), 36'h0);
		report_and_stop();
	end
endmodule : serial_command_register_decoder_tb
`default_nettype wire
